// ### include/msq_defines.svh
// Purpose: shared constants of the mux adc serial sequencer
// Assumes: 200 MHz aclk
// Notes:   times in their own units, cycle counts derived
`ifndef MSQ_DEFINES_SVH
`define MSQ_DEFINES_SVH
`define MSQ_CLK_MHZ        200
`define MSQ_T_CONV_60_US   133
`define MSQ_T_CONV_50_US   160
`define MSQ_CYC_CONV_60    (`MSQ_T_CONV_60_US * `MSQ_CLK_MHZ)
`define MSQ_CYC_CONV_50    (`MSQ_T_CONV_50_US * `MSQ_CLK_MHZ)
`define MSQ_EXT_CONV_TICKS 20480
`define MSQ_T_EXT_GAP_NS   390625
`define MSQ_CYC_EXT_GAP    ((`MSQ_T_EXT_GAP_NS * `MSQ_CLK_MHZ) / 1000)
`define MSQ_SCK_DIV        8
`define MSQ_WORD_BITS      32
`define MSQ_MUX_BITS       4
`define MSQ_REG_CTRL       8'h00
`define MSQ_REG_STAT       8'h04
`define MSQ_REG_DATA       8'h08
`define MSQ_REG_DIV        8'h0C
`define MSQ_CTRL_START     0
`define MSQ_CTRL_EXT       1
`define MSQ_CTRL_PROG      2
`define MSQ_CTRL_CHAN_LSB  4
`define MSQ_CTRL_LEN_LSB   8
`define MSQ_CTRL_F0_LSB    16
`define MSQ_STAT_BUSY      0
`define MSQ_STAT_DONE      1
`define MSQ_CTRL_RST       32'h0000_0002
`define MSQ_DIV_RST        32'h0004_0004
`define MSQ_RESP_OK        2'h0
`define MSQ_RESP_ERR       2'h2
`endif

// ### include/msq_pkg.sv
// Purpose: types of the mux adc serial sequencer
// Assumes: nothing
// Notes:   constants live in msq_defines.svh
package msq_pkg;
  typedef enum logic [1:0] {MSQ_D_CONV, MSQ_D_SLEEP, MSQ_D_OUT} msq_dev_state_t;
  typedef enum logic [2:0] {MSQ_H_IDLE, MSQ_H_PROG, MSQ_H_SEL, MSQ_H_HI, MSQ_H_LO,
                            MSQ_H_END} msq_host_state_t;
  typedef enum logic [1:0] {MSQ_F0_LOW, MSQ_F0_HIGH, MSQ_F0_EXT, MSQ_F0_EXT2} msq_f0_t;
endpackage

// ### include/msq_if.sv
// Purpose: 4-wire serial link between host and converter
// Assumes: all pins synchronous to aclk
// Notes:   resolves the two-way sck and the shared sdo line
`timescale 1ns/1ps
interface msq_if;
  logic sck_host_o;
  logic sck_host_oe;
  logic sck_dev_o;
  logic sck_dev_oe;
  logic sck;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;
  logic converter_select_n;
  logic channel_select_strobe_n;
  logic mux_din;
  logic mux_clk;
  logic rejection_clock_select;

  // weak pull-up on sck when nobody drives it
  assign sck = sck_dev_oe ? sck_dev_o : (sck_host_oe ? sck_host_o : 1'b1);
  // undriven sdo reads high
  assign sdo = sdo_oe ? sdo_o : 1'b1;
  // mux clock tied to sck for 4-wire use
  assign mux_clk = sck;

  modport dev (
    input  sck, converter_select_n, channel_select_strobe_n, mux_din, mux_clk,
    input  rejection_clock_select,
    output sck_dev_o, sck_dev_oe, sdo_o, sdo_oe
  );
  modport host (
    input  sck, sdo,
    output sck_host_o, sck_host_oe, converter_select_n, channel_select_strobe_n,
    output mux_din, rejection_clock_select
  );
endinterface

// ### logic/msq_edge.sv
// Purpose: edge detector for synchronous pin levels
// Assumes: input already synchronous to aclk
// Notes:   pulses are one cycle wide
`timescale 1ns/1ps
module msq_edge (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // level in, edges out
  input  wire logic lvl,
  output logic      rise,
  output logic      fall
);
  logic prev_q;
  logic prev_d;
  logic armed_q;
  logic armed_d;

  always_comb begin
    prev_d  = lvl;
    armed_d = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q  <= 1'b1;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      armed_q <= armed_d;
    end
  end

  // no edges until prev_q holds a real pin level, else reset fakes one
  assign rise = armed_q & lvl & ~prev_q;
  assign fall = armed_q & ~lvl & prev_q;
endmodule

// ### logic/msq_device.sv
// Purpose: converter end: conversion sequencing and 4-wire serial port
// Assumes: pins synchronous to aclk; result_word given by the analog core
// Notes:   internal conversion counts and the external clock gap are parameters so simulation can shorten them
`timescale 1ns/1ps
`include "msq_defines.svh"
// Contract
// - f0 low: 133 us conversion
// - f0 high: 160 us conversion
// - external f0: 20480 clock periods per conversion
// - notch equals 8 over conversion time
// - host keeps external f0 within limits
// - sdo changes on falling sck
// - self-clock: drive sck, conv clock over 8
// - sck mode picked at power-up, cs fall
// - strobe high: shift din on mux clk rise
// - strobe low: mux clock ignored
// - cs high: sdo released
// - cs low in convert/sleep: sdo shows eoc
// - sleep until sck rise with cs low
// - cs rise in readout aborts, restarts conversion
// - strobe fall applies shifted channel
// - channel word: enable bit then 3-bit code
// - din held zero keeps channel
// - sleep entered when conversion completes
// - host holds sck low at cs fall for external
// - host ties strobe to cs or its inverse
// - external: 32nd falling sck starts conversion
// - self-clock: after 32nd rise sck high, convert
// - new channel used from next conversion
module msq_device #(
  parameter int CYC_CONV_60 = `MSQ_CYC_CONV_60,
  parameter int CYC_CONV_50 = `MSQ_CYC_CONV_50,
  parameter int CYC_EXT_GAP = `MSQ_CYC_EXT_GAP
) (
  // clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // link
  msq_if.dev          lnk,
  // analog core side
  input  wire logic [31:0] result_word,
  output logic [2:0]  selected_channel_out,
  output logic [2:0]  conv_channel,
  output logic        conv_start,
  output logic        conv_busy,
  output logic        int_sck_mode
);
  localparam int INT_CCLK_CYC =
    (CYC_CONV_50 >= `MSQ_EXT_CONV_TICKS) ? CYC_CONV_50 / `MSQ_EXT_CONV_TICKS : 1;
  localparam int HALF_TICKS = `MSQ_SCK_DIV / 2;

  logic sck_r, sck_f, cs_r, cs_f, stb_r, stb_f, mck_r, mck_f, f0_r, f0_f;

  msq_edge u_sck (.aclk(aclk), .aresetn(aresetn), .lvl(lnk.sck),
                  .rise(sck_r), .fall(sck_f));
  msq_edge u_cs  (.aclk(aclk), .aresetn(aresetn), .lvl(lnk.converter_select_n),
                  .rise(cs_r), .fall(cs_f));
  msq_edge u_stb (.aclk(aclk), .aresetn(aresetn), .lvl(lnk.channel_select_strobe_n),
                  .rise(stb_r), .fall(stb_f));
  msq_edge u_mck (.aclk(aclk), .aresetn(aresetn), .lvl(lnk.mux_clk),
                  .rise(mck_r), .fall(mck_f));
  msq_edge u_f0  (.aclk(aclk), .aresetn(aresetn), .lvl(lnk.rejection_clock_select),
                  .rise(f0_r), .fall(f0_f));

  msq_pkg::msq_dev_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] gap_q, gap_d;
  logic [31:0] tk_q, tk_d;
  logic [31:0] sreg_q, sreg_d;
  logic [5:0]  bit_q, bit_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  chsh_q, chsh_d;
  logic [2:0]  mcnt_q, mcnt_d;
  logic [2:0]  chan_q, chan_d;
  logic [2:0]  cchan_q, cchan_d;
  logic        ext_q, ext_d;
  logic        int_q, int_d;
  logic        init_q, init_d;
  logic        sck_q, sck_d;
  logic        sdo_q, sdo_d;
  logic        start_q, start_d;
  logic        cclk;
  logic        half;
  logic [31:0] target;

  // conversion clock tick: f0 rising edges when external, divided aclk otherwise
  always_comb begin
    cclk = ext_q ? f0_r : (tk_q == 32'(INT_CCLK_CYC - 1));
    half = cclk && (ph_q == 2'(HALF_TICKS - 1));
    // notch = 8 / conversion time follows from these counts
    if (ext_q) begin
      target = 32'(`MSQ_EXT_CONV_TICKS);
    end else if (lnk.rejection_clock_select) begin
      target = 32'(CYC_CONV_50);
    end else begin
      target = 32'(CYC_CONV_60);
    end
  end

  // external conversion clock detection and divider phases
  always_comb begin
    ext_d = ext_q;
    gap_d = gap_q + 32'h1;
    if (f0_r || f0_f) begin
      ext_d = 1'b1;
      gap_d = 32'h0;
    end else if (gap_q >= 32'(CYC_EXT_GAP)) begin
      ext_d = 1'b0;
      gap_d = gap_q;
    end
    tk_d = (ext_q || tk_q == 32'(INT_CCLK_CYC - 1)) ? 32'h0 : tk_q + 32'h1;
    ph_d = cclk ? ((ph_q == 2'(HALF_TICKS - 1)) ? 2'h0 : ph_q + 2'h1) : ph_q;
  end

  // channel multiplexer shift register and apply
  always_comb begin
    chsh_d = chsh_q;
    chan_d = chan_q;
    mcnt_d = mcnt_q;
    // strobe rise opens a fresh 4-bit word; clocks after the fourth shift nothing
    if (stb_r) begin
      chsh_d = 4'h0;
      mcnt_d = 3'h0;
    end else if (lnk.channel_select_strobe_n && mck_r && !mcnt_q[2]) begin
      chsh_d = {chsh_q[2:0], lnk.mux_din};
      mcnt_d = mcnt_q + 3'h1;
    end
    // strobe low: clock edges leave both registers alone
    if (stb_f && chsh_q[3]) begin
      chan_d = chsh_q[2:0];
    end
    // enable bit zero (din held low) keeps the old channel
  end

  // main sequencer
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sreg_d  = sreg_q;
    bit_d   = bit_q;
    cchan_d = cchan_q;
    sck_d   = sck_q;
    start_d = 1'b0;
    init_d  = 1'b1;
    int_d   = int_q;
    if (!init_q) begin
      int_d = lnk.sck;
    end else if (cs_f) begin
      int_d = lnk.sck;
    end
    if (cs_f) begin
      sck_d = 1'b0;
    end
    case (st_q)
      msq_pkg::MSQ_D_CONV: begin
        cnt_d = (ext_q ? (f0_r ? cnt_q + 32'h1 : cnt_q) : cnt_q + 32'h1);
        if (cnt_d >= target) begin
          st_d   = msq_pkg::MSQ_D_SLEEP;
          sreg_d = {1'b0, result_word[30:0]};
        end
      end
      msq_pkg::MSQ_D_SLEEP: begin
        if (!lnk.converter_select_n && init_q) begin
          if (!int_q && sck_r) begin
            st_d  = msq_pkg::MSQ_D_OUT;
            bit_d = 6'h0;
          end else if (int_q && half && !cs_f) begin
            sck_d = ~sck_q;
            if (!sck_q) begin
              st_d  = msq_pkg::MSQ_D_OUT;
              bit_d = 6'h1;
            end
          end
        end
      end
      msq_pkg::MSQ_D_OUT: begin
        if (cs_r) begin
          st_d    = msq_pkg::MSQ_D_CONV;
          cnt_d   = 32'h0;
          cchan_d = chan_q;
          start_d = 1'b1;
        end else if (!int_q && sck_f) begin
          sreg_d = {sreg_q[30:0], 1'b1};
          bit_d  = bit_q + 6'h1;
          if (bit_q == 6'(`MSQ_WORD_BITS - 1)) begin
            st_d    = msq_pkg::MSQ_D_CONV;
            cnt_d   = 32'h0;
            cchan_d = chan_q;
            start_d = 1'b1;
          end
        end else if (int_q && half) begin
          sck_d = ~sck_q;
          if (sck_q) begin
            sreg_d = {sreg_q[30:0], 1'b1};
          end else begin
            bit_d = bit_q + 6'h1;
            if (bit_q == 6'(`MSQ_WORD_BITS - 1)) begin
              st_d    = msq_pkg::MSQ_D_CONV;
              cnt_d   = 32'h0;
              cchan_d = chan_q;
              start_d = 1'b1;
            end
          end
        end
      end
      default: begin
        st_d = msq_pkg::MSQ_D_CONV;
      end
    endcase
    // eoc high while converting, from the current state so the
    // last bit still stands through the 32nd self-clocked rise
    sdo_d = (st_q == msq_pkg::MSQ_D_CONV) ? 1'b1 : sreg_d[31];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= msq_pkg::MSQ_D_CONV;
      cnt_q   <= 32'h0;
      gap_q   <= 32'h0;
      tk_q    <= 32'h0;
      sreg_q  <= 32'hFFFF_FFFF;
      bit_q   <= 6'h0;
      ph_q    <= 2'h0;
      chsh_q  <= 4'h0;
      mcnt_q  <= 3'h0;
      chan_q  <= 3'h0;
      cchan_q <= 3'h0;
      ext_q   <= 1'b0;
      int_q   <= 1'b1;
      init_q  <= 1'b0;
      sck_q   <= 1'b0;
      sdo_q   <= 1'b1;
      start_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      gap_q   <= gap_d;
      tk_q    <= tk_d;
      sreg_q  <= sreg_d;
      bit_q   <= bit_d;
      ph_q    <= ph_d;
      chsh_q  <= chsh_d;
      mcnt_q  <= mcnt_d;
      chan_q  <= chan_d;
      cchan_q <= cchan_d;
      ext_q   <= ext_d;
      int_q   <= int_d;
      init_q  <= init_d;
      sck_q   <= sck_d;
      sdo_q   <= sdo_d;
      start_q <= start_d;
    end
  end

  // sck driven only in self-clock mode while selected
  assign lnk.sck_dev_o  = sck_q;
  assign lnk.sck_dev_oe = int_q & init_q & ~lnk.converter_select_n & ~cs_f;
  assign lnk.sdo_o      = sdo_q;
  assign lnk.sdo_oe     = ~lnk.converter_select_n;

  assign selected_channel_out = chan_q;
  assign conv_channel         = cchan_q;
  assign conv_start           = start_q;
  assign conv_busy            = (st_q == msq_pkg::MSQ_D_CONV);
  assign int_sck_mode         = int_q;
endmodule

// ### logic/msq_host.sv
// Purpose: host end: reads results and programs the channel over 4 wires
// Assumes: software drives it over AXI4-Lite
// Notes:   one transfer at a time; start bit self-clears
`timescale 1ns/1ps
`include "msq_defines.svh"
module msq_host (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link
  msq_if.host              lnk
);
  msq_pkg::msq_host_state_t st_q, st_d;
  logic [31:0] ctrl_q, ctrl_d, div_q, div_d, data_q, data_d, rdat_q, rdat_d;
  logic [7:0]  tk_q, tk_d, fk_q, fk_d;
  logic [5:0]  bit_q, bit_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        bv_q, bv_d, rv_q, rv_d, cs_q, cs_d, sck_q, sck_d, din_q, din_d;
  logic        f0_q, f0_d, done_q, done_d;
  logic        wr, rd, tick, ext, sck_r, sck_f;
  logic [5:0]  len;
  logic [3:0]  word;
  msq_pkg::msq_f0_t f0sel;

  msq_edge u_sck (.aclk(aclk), .aresetn(aresetn), .lvl(lnk.sck),
                  .rise(sck_r), .fall(sck_f));

  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bv_q;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = ~rv_q;

  always_comb begin
    wr    = s_axi_awready;
    rd    = s_axi_arvalid & ~rv_q;
    ext   = ctrl_q[`MSQ_CTRL_EXT];
    len   = (ctrl_q[`MSQ_CTRL_LEN_LSB +: 6] == 6'h0 || ctrl_q[`MSQ_CTRL_LEN_LSB +: 6] > 6'd32)
            ? 6'd32 : ctrl_q[`MSQ_CTRL_LEN_LSB +: 6];
    word  = {ctrl_q[`MSQ_CTRL_PROG], ctrl_q[`MSQ_CTRL_CHAN_LSB +: 3]};
    f0sel = msq_pkg::msq_f0_t'(ctrl_q[`MSQ_CTRL_F0_LSB +: 2]);
    tick  = (tk_q >= div_q[7:0]);
    tk_d  = tick ? 8'h0 : tk_q + 8'h1;
    fk_d  = (fk_q >= div_q[23:16]) ? 8'h0 : fk_q + 8'h1;
    f0_d  = (fk_q >= div_q[23:16]) ? ~f0_q : f0_q;
    ctrl_d = ctrl_q;
    div_d  = div_q;
    done_d = done_q;
    bv_d = bv_q & ~s_axi_bready;
    rv_d = rv_q & ~s_axi_rready;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    rdat_d  = rdat_q;
    if (wr) begin
      bv_d    = 1'b1;
      bresp_d = `MSQ_RESP_OK;
      if (s_axi_awaddr == `MSQ_REG_CTRL) begin
        ctrl_d = s_axi_wdata;
      end else if (s_axi_awaddr == `MSQ_REG_DIV) begin
        div_d = s_axi_wdata;
      end else if (s_axi_awaddr == `MSQ_REG_STAT) begin
        done_d = done_q & ~s_axi_wdata[`MSQ_STAT_DONE];
      end else if (s_axi_awaddr != `MSQ_REG_DATA) begin
        bresp_d = `MSQ_RESP_ERR;
      end
    end
    if (rd) begin
      rv_d    = 1'b1;
      rresp_d = `MSQ_RESP_OK;
      if (s_axi_araddr == `MSQ_REG_CTRL) begin
        rdat_d = ctrl_q;
      end else if (s_axi_araddr == `MSQ_REG_STAT) begin
        rdat_d = {30'h0, done_q, (st_q != msq_pkg::MSQ_H_IDLE)};
      end else if (s_axi_araddr == `MSQ_REG_DATA) begin
        rdat_d = data_q;
      end else if (s_axi_araddr == `MSQ_REG_DIV) begin
        rdat_d = div_q;
      end else begin
        rdat_d  = 32'h0;
        rresp_d = `MSQ_RESP_ERR;
      end
    end
    st_d = st_q;
    cs_d = cs_q;
    sck_d = sck_q;
    din_d = din_q;
    bit_d = bit_q;
    data_d = data_q;
    case (st_q)
      msq_pkg::MSQ_H_IDLE: begin
        if (ctrl_q[`MSQ_CTRL_START]) begin
          ctrl_d[`MSQ_CTRL_START] = 1'b0;
          bit_d = 6'h0;
          din_d = word[3];
          if (ext && word[3]) begin
            st_d = msq_pkg::MSQ_H_PROG;
          end else begin
            st_d = msq_pkg::MSQ_H_SEL;
            cs_d = 1'b0;
          end
        end
      end
      msq_pkg::MSQ_H_PROG: begin
        if (tick) begin
          sck_d = ~sck_q;
          if (sck_q) begin
            bit_d = bit_q + 6'h1;
            din_d = (bit_q < 6'h3) ? word[2'(6'h2 - bit_q)] : 1'b0;
            if (bit_q == 6'h3) begin
              st_d  = msq_pkg::MSQ_H_SEL;
              bit_d = 6'h0;
              cs_d  = 1'b0;
            end
          end
        end
      end
      msq_pkg::MSQ_H_SEL: begin
        if (ext && tick && !lnk.sdo) begin
          st_d = msq_pkg::MSQ_H_HI;
        end else if (!ext && sck_r) begin
          data_d = {data_q[30:0], lnk.sdo};
          bit_d  = bit_q + 6'h1;
          if (bit_q + 6'h1 == len) begin
            st_d = msq_pkg::MSQ_H_END;
          end
        end else if (!ext && sck_f) begin
          din_d = (bit_q < 6'h4) ? word[2'(6'h3 - bit_q)] : 1'b0;
        end
      end
      msq_pkg::MSQ_H_HI: begin
        if (tick) begin
          sck_d  = 1'b1;
          data_d = {data_q[30:0], lnk.sdo};
          bit_d  = bit_q + 6'h1;
          st_d   = msq_pkg::MSQ_H_LO;
        end
      end
      msq_pkg::MSQ_H_LO: begin
        if (tick) begin
          sck_d = 1'b0;
          st_d  = (bit_q == len) ? msq_pkg::MSQ_H_END : msq_pkg::MSQ_H_HI;
        end
      end
      msq_pkg::MSQ_H_END: begin
        if (tick) begin
          cs_d   = 1'b1;
          din_d  = 1'b0;
          st_d   = msq_pkg::MSQ_H_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        st_d = msq_pkg::MSQ_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= msq_pkg::MSQ_H_IDLE;
      ctrl_q <= `MSQ_CTRL_RST;
      div_q <= `MSQ_DIV_RST;
      data_q <= 32'h0;
      rdat_q <= 32'h0;
      tk_q <= 8'h0;
      fk_q <= 8'h0;
      bit_q <= 6'h0;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      {bv_q, rv_q, sck_q, din_q, f0_q, done_q} <= 6'h0;
      cs_q <= 1'b1;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      div_q <= div_d;
      data_q <= data_d;
      rdat_q <= rdat_d;
      tk_q <= tk_d;
      fk_q <= fk_d;
      bit_q <= bit_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      {bv_q, rv_q, sck_q, din_q, f0_q, done_q} <= {bv_d, rv_d, sck_d, din_d, f0_d, done_d};
      cs_q <= cs_d;
    end
  end

  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata  = rdat_q;
  assign s_axi_rresp  = rresp_q;
  assign lnk.sck_host_o  = sck_q;
  assign lnk.sck_host_oe = ext;
  assign lnk.converter_select_n = cs_q;
  // strobe follows cs in external mode, its inverse in self-clock mode
  assign lnk.channel_select_strobe_n = ext ? cs_q : ~cs_q;
  assign lnk.mux_din = din_q;
  assign lnk.rejection_clock_select = f0sel[1] ? f0_q : f0sel[0];
endmodule

// ### dv/msq_sva.sv
// Purpose: checks on the 4-wire link and on conversion timing
// Assumes: inputs are the interface signals and device status outputs
// Notes:   conversion lengths use the shortened parameters of the bench
`timescale 1ns/1ps
module msq_sva #(
  parameter int CYC_CONV_60 = 200,
  parameter int CYC_CONV_50 = 256
) (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // link
  input wire logic       sck,
  input wire logic       sck_dev_oe,
  input wire logic       sdo_o,
  input wire logic       sdo_oe,
  input wire logic       converter_select_n,
  input wire logic       channel_select_strobe_n,
  input wire logic       rejection_clock_select,
  // device status
  input wire logic [2:0] selected_channel_out,
  input wire logic       conv_start,
  input wire logic       conv_busy,
  input wire logic       int_sck_mode
);
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;
  logic        f0_q;
  logic        f0_d;
  logic        f0_mix_q;
  logic        f0_mix_d;

  // length of each conversion and whether f0 moved during it
  always_comb begin
    busy_cnt_d = conv_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
    f0_d       = (busy_cnt_q == 16'h0000) ? rejection_clock_select : f0_q;
    f0_mix_d   = (busy_cnt_q == 16'h0000) ? 1'b0 : (f0_mix_q | (rejection_clock_select != f0_q));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_cnt_q <= 16'h0000;
      f0_q       <= 1'b0;
      f0_mix_q   <= 1'b1;
    end else begin
      busy_cnt_q <= busy_cnt_d;
      f0_q       <= f0_d;
      f0_mix_q   <= f0_mix_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_conv_watched;
    (conv_busy && !converter_select_n) [*3];
  endsequence

  sequence s_sleep_unselected;
    (converter_select_n && !conv_busy) [*4];
  endsequence

  a_conv_len_60: assert property ($fell(conv_busy) && !f0_mix_q && !f0_q |->
    busy_cnt_q inside {[CYC_CONV_60-2:CYC_CONV_60+2]}) else $error("60Hz conversion length");
  a_conv_len_50: assert property ($fell(conv_busy) && !f0_mix_q && f0_q |->
    busy_cnt_q inside {[CYC_CONV_50-2:CYC_CONV_50+2]}) else $error("50Hz conversion length");
  a_sdo_on_fall: assert property ($changed(sdo_o) && sdo_oe && $past(sdo_oe) &&
    $past(sdo_oe, 2) && !conv_busy && !$past(conv_busy) && !$past(conv_busy, 2) |-> !sck)
    else $error("sdo moved while sck high");
  a_ext_no_drive: assert property (!int_sck_mode && $past(!int_sck_mode) |-> !sck_dev_oe)
    else $error("sck driven in external mode");
  a_mode_self: assert property ($fell(converter_select_n) && sck |-> ##[1:3] int_sck_mode)
    else $error("self clock mode not chosen");
  a_mode_ext: assert property ($fell(converter_select_n) && !sck |-> ##[1:3] !int_sck_mode)
    else $error("external clock mode not chosen");
  a_strobe_hold: assert property ((!channel_select_strobe_n) [*4] |->
    $stable(selected_channel_out)) else $error("channel moved with strobe low");
  a_sdo_release: assert property (converter_select_n && $past(converter_select_n) &&
    $past(converter_select_n, 2) |-> !sdo_oe) else $error("sdo driven while deselected");
  a_eoc_busy: assert property (s_conv_watched |-> sdo_oe && sdo_o)
    else $error("busy flag missing on sdo");
  a_sleep_hold: assert property (s_sleep_unselected |=> !conv_busy)
    else $error("sleep left while deselected");
  a_start_busy: assert property (conv_start |-> ##[0:1] (conv_busy [*3]))
    else $error("start pulse without conversion");
endmodule

// ### dv/mux_adc_serial_sequencer_tb.sv
// Purpose: self-checking bench for host and converter ends joined by the link
// Assumes: shortened conversion counts
// Notes:   reads and channel changes are noted in queues and checked by watchers
`timescale 1ns/1ps
`include "msq_defines.svh"
module mux_adc_serial_sequencer_tb;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} msq_note_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, conv_start, conv_busy, int_mode;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, result_word, d;
  logic [1:0]  bresp, rresp;
  logic [2:0]  chan_out, conv_chan;
  msq_note_t   rq[$];
  logic [1:0]  bq[$];
  logic [2:0]  cq[$];
  logic [3:0]  wstrb;
  int          num_errors, n_compared, cyc;

  msq_if lnk();
  msq_device #(.CYC_CONV_60(200), .CYC_CONV_50(256), .CYC_EXT_GAP(64)) msq_device_inst (
    .aclk(aclk), .aresetn(aresetn), .lnk(lnk), .result_word(result_word),
    .selected_channel_out(chan_out), .conv_channel(conv_chan), .conv_start(conv_start),
    .conv_busy(conv_busy), .int_sck_mode(int_mode));
  msq_host msq_host_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lnk(lnk));
  msq_sva #(.CYC_CONV_60(200), .CYC_CONV_50(256)) msq_sva_inst (
    .aclk(aclk), .aresetn(aresetn), .sck(lnk.sck), .sck_dev_oe(lnk.sck_dev_oe),
    .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe), .converter_select_n(lnk.converter_select_n),
    .channel_select_strobe_n(lnk.channel_select_strobe_n),
    .rejection_clock_select(lnk.rejection_clock_select), .selected_channel_out(chan_out),
    .conv_start(conv_start), .conv_busy(conv_busy), .int_sck_mode(int_mode));

  always #2.5 aclk = ~aclk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchers take the oldest note when a result appears
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      give_verdict();
    end
    if (aresetn && rvalid && rready && rq.size() > 0) begin
      check("rdata", rdata & rq[0].m, rq[0].d & rq[0].m);
      check("rresp", {30'h0, rresp}, {30'h0, rq[0].r});
      void'(rq.pop_front());
    end
    if (aresetn && bvalid && bready && bq.size() > 0) begin
      check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
    end
  end

  always @(chan_out) begin
    if (aresetn && cq.size() > 0) check("channel", {29'h0, chan_out}, {29'h0, cq.pop_front()});
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(r);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready  <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input msq_note_t n, output logic [31:0] v);
    rq.push_back(n);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    rready  <= 1'b0;
    @(posedge aclk);
  endtask

  // start one transfer, wait for done, read the word back
  task automatic xfer(input logic [31:0] ctrl, input logic [31:0] m);
    logic [31:0] s;
    int          l;
    s = 32'h0;
    l = ctrl[`MSQ_CTRL_LEN_LSB +: 6];
    axi_wr(`MSQ_REG_CTRL, ctrl | 32'h0000_0001, `MSQ_RESP_OK);
    while (s[1] !== 1'b1) axi_rd(`MSQ_REG_STAT, '{32'h0, 32'h0, `MSQ_RESP_OK}, s);
    axi_wr(`MSQ_REG_STAT, 32'h0000_0002, `MSQ_RESP_OK);
    axi_rd(`MSQ_REG_DATA, '{{1'b0, result_word[30:0]} >> (32 - l), m, `MSQ_RESP_OK}, s);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, result_word} = 80'h0;
    wstrb = 4'hF;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    void'($urandom(20463));
    axi_rd(`MSQ_REG_CTRL, '{`MSQ_CTRL_RST, 32'hFFFF_FFFF, `MSQ_RESP_OK}, d);
    axi_rd(`MSQ_REG_DIV, '{`MSQ_DIV_RST, 32'hFFFF_FFFF, `MSQ_RESP_OK}, d);
    axi_rd(8'h10, '{32'h0, 32'hFFFF_FFFF, `MSQ_RESP_ERR}, d);
    axi_wr(8'h10, $urandom, `MSQ_RESP_ERR);
    $display("test registers done");
    // both clock modes against both rejection settings
    for (int i = 0; i < 4; i++) begin
      result_word <= $urandom;
      xfer({15'h0, i[1], 2'h0, 6'h20, 6'h0, i[0], 1'b0}, 32'h0);
      xfer({15'h0, i[1], 2'h0, 6'h20, 6'h0, i[0], 1'b0}, 32'hFFFF_FFFF);
    end
    $display("test read modes done");
    for (int k = 1; k <= 8; k++) begin
      cq.push_back(k[2:0]);
      xfer({18'h0, 6'h20, 1'b0, k[2:0], 4'h6}, 32'h0);
      check("conv_channel", {29'h0, conv_chan}, {29'h0, k[2:0]});
    end
    xfer(32'h0000_2032, 32'h0);
    check("held channel", {29'h0, chan_out}, 32'h0);
    $display("test channels done");
    for (int j = 0; j < 2; j++) begin
      result_word <= $urandom;
      xfer({30'h0000_0200, j[0], 1'b0}, 32'h0000_00FF);
      xfer({30'h0000_0800, j[0], 1'b0}, 32'hFFFF_FFFF);
    end
    $display("test abort done");
    give_verdict();
  end
endmodule
